// >>> core/servo_control_input_select.sv
`timescale 1ns/1ps

module servo_control_input_select #(
  parameter int POWERUP_CYCLES = servo_input_pkg::POWERUP_CYCLES
) (
  input  wire logic                             clock,
  input  wire logic                             nrst,
  input  wire servo_input_pkg::ctrl_in_s        pins,
  input  wire logic [servo_input_pkg::PARAM_W-1:0] setup_param_one,
  input  wire logic [servo_input_pkg::PARAM_W-1:0] setup_param_two,
  output servo_input_pkg::ctrl_out_s            ctrl,
  output servo_input_pkg::mp_func_e             mp_func,
  output logic                                  powerup_done
);

  // ----------------------------------------
  // Synchroniser
  // ----------------------------------------
  servo_input_pkg::ctrl_in_s meta_q;
  servo_input_pkg::ctrl_in_s sync_q;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pins;
      sync_q <= meta_q;
    end
  end

  // ----------------------------------------
  // Power-up timer
  // ----------------------------------------
  localparam int CW = $clog2(POWERUP_CYCLES + 1);
  logic [CW-1:0] pu_cnt_q;
  logic          pu_done_q;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pu_cnt_q  <= '0;
      pu_done_q <= 1'b0;
    end else if (!pu_done_q) begin
      if (pu_cnt_q == CW'(POWERUP_CYCLES - 1)) begin
        pu_done_q <= 1'b1;
      end
      pu_cnt_q <= pu_cnt_q + CW'(1);
    end
  end

  assign powerup_done = pu_done_q;

  // ----------------------------------------
  // Function decode
  // ----------------------------------------
  function automatic servo_input_pkg::mp_func_e decode_func(
    input logic func_bit,
    input logic ext_bit
  );
    if (func_bit) begin
      return servo_input_pkg::FUNC_DIRECTION;
    end else if (ext_bit) begin
      return servo_input_pkg::FUNC_PULSE_INHIBIT;
    end
    return servo_input_pkg::FUNC_GAIN_REDUCE;
  endfunction

  servo_input_pkg::mp_func_e func_d;
  servo_input_pkg::mp_func_e func_q;
  logic                      bypass_q;
  logic                      func_sel_bit;
  logic                      ext_sel_bit;

  assign func_sel_bit = setup_param_two[servo_input_pkg::FUNC_SELECT_BIT];
  assign ext_sel_bit  = setup_param_one[servo_input_pkg::EXT_SELECT_BIT];
  assign func_d       = decode_func(func_sel_bit, ext_sel_bit);

  always_ff @(posedge clock) begin
    if (!nrst) begin
      func_q   <= servo_input_pkg::FUNC_GAIN_REDUCE;
      bypass_q <= 1'b0;
    end else begin
      func_q   <= func_d;
      bypass_q <= setup_param_one[servo_input_pkg::RUN_BYPASS_BIT];
    end
  end

  assign mp_func = func_q;

  // ----------------------------------------
  // Output decode
  // ----------------------------------------
  servo_input_pkg::ctrl_out_s ctrl_d;
  servo_input_pkg::ctrl_out_s ctrl_q;
  logic                       gain_reduce_in;
  logic                       pulse_inhibit_in;
  logic                       internal_speed_direction_in;
  logic                       speed_select_one;
  logic                       speed_select_two;
  logic                       dir_mode;

  always_comb begin
    gain_reduce_in              = 1'b0;
    pulse_inhibit_in            = 1'b0;
    internal_speed_direction_in = 1'b0;
    case (func_q)
      servo_input_pkg::FUNC_GAIN_REDUCE: begin
        gain_reduce_in = sync_q.multi_in;
      end
      servo_input_pkg::FUNC_PULSE_INHIBIT: begin
        pulse_inhibit_in = sync_q.multi_in;
      end
      servo_input_pkg::FUNC_DIRECTION: begin
        internal_speed_direction_in = sync_q.multi_in;
      end
      default: begin
        gain_reduce_in = 1'b0;
      end
    endcase
  end

  assign dir_mode         = (func_q == servo_input_pkg::FUNC_DIRECTION);
  assign speed_select_one = dir_mode & sync_q.forward_current_limit_in;
  assign speed_select_two = dir_mode & sync_q.reverse_current_limit_in;

  always_comb begin
    ctrl_d = '0;
    ctrl_d.drive_enable = bypass_q ? pu_done_q
                                   : (pu_done_q & sync_q.run_in);
    ctrl_d.integrator_disable  = gain_reduce_in;
    ctrl_d.low_gain            = gain_reduce_in;
    ctrl_d.pulse_discard       = pulse_inhibit_in;
    ctrl_d.internal_speed_mode = dir_mode;
    ctrl_d.reverse_dir         = internal_speed_direction_in;
    ctrl_d.speed_sel = servo_input_pkg::speed_sel_e'(
      {speed_select_two, speed_select_one});
    ctrl_d.forward_limit = !dir_mode & sync_q.forward_current_limit_in;
    ctrl_d.reverse_limit = !dir_mode & sync_q.reverse_current_limit_in;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      ctrl_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  assign ctrl = ctrl_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_run_off_no_drive: assert property (@(posedge clock)
    disable iff (!nrst)
    (!bypass_q && !sync_q.run_in) |=> !ctrl_q.drive_enable)
    else $error("drive enabled without run");

  a_run_on_drive: assert property (@(posedge clock)
    disable iff (!nrst)
    (!bypass_q && sync_q.run_in && pu_done_q) |=> ctrl_q.drive_enable)
    else $error("run did not enable drive");

  a_bypass_ignores_run: assert property (@(posedge clock)
    disable iff (!nrst)
    (bypass_q && pu_done_q) |=> ctrl_q.drive_enable)
    else $error("bypass did not force drive");

  a_auto_servo_on: assert property (@(posedge clock)
    disable iff (!nrst)
    $rose(pu_done_q) && bypass_q && $stable(bypass_q)
      |=> ctrl_q.drive_enable)
    else $error("no automatic servo on");

  a_powerup_hold: assert property (@(posedge clock)
    disable iff (!nrst)
    !pu_done_q |=> !ctrl_q.drive_enable)
    else $error("drive enabled before power-up");

  a_func_decode: assert property (@(posedge clock)
    disable iff (!nrst)
    nrst |=> func_q == ($past(func_sel_bit) ? servo_input_pkg::FUNC_DIRECTION
      : $past(ext_sel_bit) ? servo_input_pkg::FUNC_PULSE_INHIBIT
      : servo_input_pkg::FUNC_GAIN_REDUCE))
    else $error("function decode wrong");

  a_gain_integ: assert property (@(posedge clock)
    disable iff (!nrst)
    (func_q == servo_input_pkg::FUNC_GAIN_REDUCE && sync_q.multi_in)
      |=> ctrl_q.integrator_disable && ctrl_q.low_gain)
    else $error("gain reduction not applied");

  a_gain_release: assert property (@(posedge clock)
    disable iff (!nrst)
    !sync_q.multi_in |=> !ctrl_q.low_gain && !ctrl_q.reverse_dir)
    else $error("gain not restored");

  a_pulse_discard: assert property (@(posedge clock)
    disable iff (!nrst)
    ctrl_q.pulse_discard == ($past(sync_q.multi_in)
      && $past(func_q) == servo_input_pkg::FUNC_PULSE_INHIBIT))
    else $error("pulse discard wrong");

  a_dir_reverse: assert property (@(posedge clock)
    disable iff (!nrst)
    (dir_mode && sync_q.multi_in) |=> ctrl_q.reverse_dir
      && ctrl_q.internal_speed_mode)
    else $error("direction not reverse");

  a_speed_select: assert property (@(posedge clock)
    disable iff (!nrst)
    !dir_mode |=> ctrl_q.speed_sel == servo_input_pkg::SPEED_NONE)
    else $error("speed select outside direction mode");

endmodule

// >>> include/servo_input_pkg.sv
package servo_input_pkg;

  // ----------------------------------------
  // Setup bit positions
  // ----------------------------------------
  localparam int RUN_BYPASS_BIT   = 0;
  localparam int EXT_SELECT_BIT   = 15;
  localparam int FUNC_SELECT_BIT  = 2;
  localparam int PARAM_W          = 16;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLOCK_MHZ        = 200;
  localparam int POWERUP_NS       = 1000;
  localparam int POWERUP_CYCLES   = (POWERUP_NS * CLOCK_MHZ + 999) / 1000;
  localparam int SYNC_STAGES      = 2;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    FUNC_GAIN_REDUCE,
    FUNC_PULSE_INHIBIT,
    FUNC_DIRECTION
  } mp_func_e;

  typedef enum logic [1:0] {
    SPEED_NONE,
    SPEED_ONE,
    SPEED_TWO,
    SPEED_THREE
  } speed_sel_e;

  typedef struct packed {
    logic run_in;
    logic multi_in;
    logic forward_current_limit_in;
    logic reverse_current_limit_in;
  } ctrl_in_s;

  typedef struct packed {
    logic       drive_enable;
    logic       integrator_disable;
    logic       low_gain;
    logic       pulse_discard;
    logic       internal_speed_mode;
    logic       reverse_dir;
    speed_sel_e speed_sel;
    logic       forward_limit;
    logic       reverse_limit;
  } ctrl_out_s;

endpackage

// >>> test/host_ctrl_model.sv
`timescale 1ns/1ps

// Host holds each level from the clock edge after the one it is told at
module host_ctrl_model (
  input  wire logic                      clock,
  input  wire servo_input_pkg::ctrl_in_s want,
  output servo_input_pkg::ctrl_in_s      pins
);
  always_ff @(posedge clock) pins <= want;
endmodule

// >>> test/servo_control_input_select_tb.sv
`timescale 1ns/1ps

module servo_control_input_select_tb;
  localparam int PUP = 4;
  logic                       clock;
  logic                       nrst;
  servo_input_pkg::ctrl_in_s  want;
  servo_input_pkg::ctrl_in_s  pins;
  logic [15:0]                p1;
  logic [15:0]                p2;
  servo_input_pkg::ctrl_out_s ctrl;
  servo_input_pkg::mp_func_e  mp_func;
  logic                       powerup_done;
  logic                       chk;
  logic [11:0]                exp_q[$];
  int                         n_errors;
  int                         n_tests;
  int                         cycles;
  int                         seed;
  logic [31:0]                r;
  logic [15:0]                rnd_one;
  logic [15:0]                rnd_two;

  host_ctrl_model i_host_ctrl_model (.clock(clock), .want(want), .pins(pins));

  servo_control_input_select #(
    .POWERUP_CYCLES(PUP)
  ) i_servo_control_input_select (
    .clock(clock), .nrst(nrst), .pins(pins), .setup_param_one(p1),
    .setup_param_two(p2), .ctrl(ctrl), .mp_func(mp_func),
    .powerup_done(powerup_done));

  // ------------------------------
  // Helpers
  // ------------------------------
  task automatic cmp_out(input logic [11:0] e, input logic [11:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] ctrl_and_func exp %h got %h", e, g);
    end
  endtask

  task automatic cmp_bit(input string n, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %b got %b", n, e, g);
    end
  endtask

  task automatic summarize;
    if (n_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  function automatic logic [11:0] expect_out(servo_input_pkg::ctrl_in_s w,
                                             logic [15:0] a, logic [15:0] b);
    servo_input_pkg::ctrl_out_s o;
    servo_input_pkg::mp_func_e  f;
    logic                       fs;
    logic                       m;
    logic                       fwd;
    logic                       rev;
    o = '0;
    fs = b[servo_input_pkg::FUNC_SELECT_BIT];
    m = w.multi_in;
    fwd = w.forward_current_limit_in;
    rev = w.reverse_current_limit_in;
    f = servo_input_pkg::FUNC_GAIN_REDUCE;
    if (fs) begin
      f = servo_input_pkg::FUNC_DIRECTION;
    end else if (a[servo_input_pkg::EXT_SELECT_BIT]) begin
      f = servo_input_pkg::FUNC_PULSE_INHIBIT;
    end
    o.drive_enable = a[servo_input_pkg::RUN_BYPASS_BIT] | w.run_in;
    o.integrator_disable = m && f == servo_input_pkg::FUNC_GAIN_REDUCE;
    o.low_gain = o.integrator_disable;
    o.pulse_discard = m && f == servo_input_pkg::FUNC_PULSE_INHIBIT;
    o.internal_speed_mode = fs;
    o.reverse_dir = fs && m;
    o.speed_sel = servo_input_pkg::speed_sel_e'(fs ? {rev, fwd} : 2'h0);
    o.forward_limit = !fs && fwd;
    o.reverse_limit = !fs && rev;
    return {o, f};
  endfunction

  task automatic step(input logic [3:0] w, input logic [15:0] a, b);
    want <= w;
    p1 <= a;
    p2 <= b;
    repeat (6) @(posedge clock);
    exp_q.push_back(expect_out(w, a, b));
    chk <= 1'b1;
    @(posedge clock);
    chk <= 1'b0;
  endtask

  task automatic power_up;
    nrst <= 1'b0;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    repeat (PUP - 1) @(posedge clock);
    @(negedge clock) cmp_bit("powerup_done", 1'b0, powerup_done);
    repeat (4) @(posedge clock);
    @(negedge clock) cmp_bit("powerup_done", 1'b1, powerup_done);
    @(posedge clock);
  endtask

  // ------------------------------
  // Clock, watchdog, monitor
  // ------------------------------
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      summarize();
    end
  end

  always @(negedge clock) begin
    if (chk === 1'b1) begin
      cmp_out(exp_q.pop_front(), {ctrl, mp_func});
    end
    if (nrst === 1'b1 && powerup_done !== 1'b1) begin
      cmp_bit("drive_enable", 1'b0, ctrl.drive_enable);
    end
  end

  // ------------------------------
  // Sequence
  // ------------------------------
  initial begin
    seed = 32'hc3632d80;
    want = '0;
    p1 = 16'h0001;
    p2 = 16'h0000;
    chk = 1'b0;
    power_up();
    step(4'h0, 16'h0001, 16'h0000);
    step(4'h8, 16'h0000, 16'h0000);
    step(4'h0, 16'h0000, 16'h0000);
    step(4'h4, 16'h8000, 16'h0000);
    step(4'h7, 16'h0000, 16'h0004);
    for (int i = 0; i < 48; i++) begin
      r = $random(seed);
      rnd_one = {i[0], r[14:1], r[16]};
      rnd_two = {r[31:19], i[1], r[18:17]};
      step(r[3:0], rnd_one, rnd_two);
    end
    power_up();
    step(4'h0, 16'h0001, 16'h0000);
    summarize();
  end
endmodule
